// ==== hw/root_hub_descriptor_config_defines.svh ====
// Offsets, field positions, reset values and timing counts of the root hub descriptor
`ifndef ROOT_HUB_DESCRIPTOR_CONFIG_DEFINES_SVH
`define ROOT_HUB_DESCRIPTOR_CONFIG_DEFINES_SVH

// Register byte address and low decode bits
`define RHD_A_ADDR         32'h90101048
`define RHD_A_OFFSET       12'h048

// Field positions
`define RHD_PGW_MSB        31
`define RHD_PGW_LSB        24
`define RHD_NOOC_BIT       12
`define RHD_OCRM_BIT       11
`define RHD_CDF_BIT        10
`define RHD_PSWM_BIT       9
`define RHD_PSA_BIT        8
`define RHD_NPORT_MSB      7
`define RHD_NPORT_LSB      0

// Implementation reset values
`define RHD_PGW_RESET      8'h01
`define RHD_NOOC_RESET     1'h0
`define RHD_PSWM_RESET     1'h1
`define RHD_PSA_RESET      1'h0
`define RHD_NPORT_VALUE    8'h0f
`define RHD_CDF_VALUE      1'h0
`define RHD_NPORT_MAX      8'h0f

// Power-good wait unit
`define RHD_PGW_UNIT_MS    2
`define RHD_CLK_MHZ        250
`define RHD_CYC_PER_UNIT   (`RHD_PGW_UNIT_MS * 1000 * `RHD_CLK_MHZ)

`endif

// ==== hw/root_hub_descriptor_config_pkg.sv ====
// Types shared by the root hub descriptor block
package root_hub_descriptor_config_pkg;

  typedef struct packed {
    logic [7:0] power_good_wait_units;
    logic       no_overcurrent_protect;
    logic       overcurrent_report_mode;
    logic       power_switch_mode;
    logic       power_switch_absent;
  } rhd_fields_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    PWR_GANGED      = 2'b00,
    PWR_PER_PORT    = 2'b01,
    PWR_ALWAYS_ON   = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    OC_COLLECTIVE   = 2'b00,
    OC_PER_PORT     = 2'b01,
    OC_NONE         = 2'b11
  } oc_mode_t;

endpackage : root_hub_descriptor_config_pkg

// ==== hw/root_hub_descriptor_config.sv ====
// Root hub descriptor register with APB slave and decoded mode outputs
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "root_hub_descriptor_config_defines.svh"

// Notes on behaviour
// - Top byte is read/write power-good wait, one unit equals 2 ms.
// - Bit 12 set means no overcurrent protection; clear lets bit 11 choose.
// - Bit 11 picks collective or per-port overcurrent reporting, only if bit 12 clear.
// - Overcurrent mode resets to the same value as power switch mode.
// - Bit 10 is read-only and always reads zero.
// - Bit 9 clear powers ports together, set powers each port individually.
// - Per-port mode: masked ports obey port commands, unmasked follow global switch.
// - Bit 8 set means ports always powered; clear means power switched.
// - Bits 7 to 0 report port count, between one and fifteen, read-only.
// - Wait, overcurrent and power switch fields are software writable.
// - Register is accessed only as whole 32-bit words.
// - Writes are accepted in any host controller operational state.

module root_hub_descriptor_config (
  // Clock and reset
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // APB slave
  input  wire root_hub_descriptor_config_pkg::apb_req_t apb_req,
  output var  root_hub_descriptor_config_pkg::apb_rsp_t apb_rsp,
  // Per-port power mask and power commands
  input  wire logic [15:0]                           port_power_mask,
  input  wire logic                                  global_power_command,
  input  wire logic                                  global_power_value,
  input  wire logic [15:0]                           per_port_power_command,
  input  wire logic [15:0]                           per_port_power_value,
  // Decoded configuration
  output var  root_hub_descriptor_config_pkg::power_mode_t power_mode,
  output var  root_hub_descriptor_config_pkg::oc_mode_t    oc_mode,
  output logic [7:0]                                 power_good_wait_units,
  output logic [31:0]                                power_good_wait_cycles,
  output logic [15:0]                                port_power_on
);
  import root_hub_descriptor_config_pkg::*;

  // ==========================================================
  // Register state
  rhd_fields_t fields_r;
  logic [15:0] port_pwr_r;
  wire logic [15:0] port_pwr_nxt;
  logic [31:0] prdata_r;

  // ==========================================================
  // Decode
  wire logic        sel_reg;
  wire logic        full_word;
  wire logic        wr_hit;
  wire logic        rd_take;
  wire logic        bad_acc;
  wire logic [31:0] reg_word;
  wire logic        rd_acc;
  wire logic        wr_acc;

  assign sel_reg   = (apb_req.paddr[11:0] == `RHD_A_OFFSET);
  assign full_word = (apb_req.pstrb == 4'hf);
  assign wr_hit    = apb_req.psel && apb_req.penable && apb_req.pwrite
                     && sel_reg && full_word;
  assign rd_take   = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign bad_acc   = !sel_reg || (apb_req.pwrite && !full_word);
  assign rd_acc    = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign wr_acc    = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // Bits 23..13 and bit 10 forced to zero, port count constant
  assign reg_word = {fields_r.power_good_wait_units,
                     11'h000,
                     fields_r.no_overcurrent_protect,
                     fields_r.overcurrent_report_mode,
                     `RHD_CDF_VALUE,
                     fields_r.power_switch_mode,
                     fields_r.power_switch_absent,
                     `RHD_NPORT_VALUE};

  // ==========================================================
  // APB answer: zero wait states, error on unmapped or partial write
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && bad_acc;
  assign apb_rsp.prdata  = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fields_r.power_good_wait_units   <= `RHD_PGW_RESET;
      fields_r.no_overcurrent_protect  <= `RHD_NOOC_RESET;
      fields_r.overcurrent_report_mode <= `RHD_PSWM_RESET;
      fields_r.power_switch_mode       <= `RHD_PSWM_RESET;
      fields_r.power_switch_absent     <= `RHD_PSA_RESET;
    end else if (wr_hit) begin
      fields_r.power_good_wait_units   <= apb_req.pwdata[`RHD_PGW_MSB:`RHD_PGW_LSB];
      fields_r.no_overcurrent_protect  <= apb_req.pwdata[`RHD_NOOC_BIT];
      fields_r.overcurrent_report_mode <= apb_req.pwdata[`RHD_OCRM_BIT];
      fields_r.power_switch_mode       <= apb_req.pwdata[`RHD_PSWM_BIT];
      fields_r.power_switch_absent     <= apb_req.pwdata[`RHD_PSA_BIT];
    end
  end

  // Read data captured in setup so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (rd_take) begin
      prdata_r <= sel_reg ? reg_word : 32'h00000000;
    end
  end

  // ==========================================================
  // Decoded modes
  assign power_mode = fields_r.power_switch_absent ? PWR_ALWAYS_ON :
                      (fields_r.power_switch_mode ? PWR_PER_PORT : PWR_GANGED);
  assign oc_mode    = fields_r.no_overcurrent_protect ? OC_NONE :
                      (fields_r.overcurrent_report_mode ? OC_PER_PORT : OC_COLLECTIVE);
  assign power_good_wait_units  = fields_r.power_good_wait_units;
  assign power_good_wait_cycles = 32'(fields_r.power_good_wait_units) * 32'(`RHD_CYC_PER_UNIT);

  // ==========================================================
  // Port power; bit 0 unused, ports 1..15
  assign port_pwr_nxt[0] = 1'b0;

  generate
    for (genvar i = 1; i < 16; i++) begin : g_port
      wire logic by_port;
      wire logic by_global;
      wire logic port_hit;
      assign by_port   = (power_mode == PWR_PER_PORT) && port_power_mask[i];
      assign by_global = !by_port && global_power_command;
      assign port_hit  = by_port && per_port_power_command[i];
      assign port_pwr_nxt[i] = (power_mode == PWR_ALWAYS_ON) ? 1'b1 :
                               port_hit  ? per_port_power_value[i] :
                               by_global ? global_power_value :
                               port_pwr_r[i];

      a_port_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (power_mode == PWR_PER_PORT && port_power_mask[i] && per_port_power_command[i])
          |=> port_power_on[i] == $past(per_port_power_value[i]))
        else $error("masked port missed its own command");

      a_port_global: assert property (@(posedge pclk) disable iff (!presetn)
        (power_mode == PWR_PER_PORT && !port_power_mask[i] && global_power_command)
          |=> port_power_on[i] == $past(global_power_value))
        else $error("unmasked port missed the global switch");
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pwr_r <= 16'h0000;
    end else begin
      port_pwr_r <= port_pwr_nxt;
    end
  end

  assign port_power_on = port_pwr_r;

  // ==========================================================
  // Checks
  a_cdf_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && !apb_req.pwrite) |-> !apb_rsp.prdata[`RHD_CDF_BIT])
    else $error("compound flag read as one");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && !apb_req.pwrite) |-> apb_rsp.prdata[23:13] == 11'h000)
    else $error("reserved bits not zero");

  a_port_range: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && !apb_req.pwrite && sel_reg) |->
      (apb_rsp.prdata[7:0] != 8'h00 && apb_rsp.prdata[7:0] <= `RHD_NPORT_MAX))
    else $error("port count out of range");

  a_pgw_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> power_good_wait_units == $past(apb_req.pwdata[31:24]))
    else $error("power-good wait not written");

  a_pgw_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    power_good_wait_cycles == 32'(power_good_wait_units) * 32'd500000)
    else $error("wait cycles mismatch");

  a_partial_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && apb_req.pwrite && !full_word) |=> $stable(fields_r))
    else $error("partial write changed register");

  a_oc_mode: assert property (@(posedge pclk) disable iff (!presetn)
    fields_r.no_overcurrent_protect |-> oc_mode == OC_NONE)
    else $error("overcurrent mode ignores protect bit");

  a_always_on: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == PWR_ALWAYS_ON) |=> port_power_on[15:1] == 15'h7fff)
    else $error("ports not powered in always-on mode");

  a_masked_port: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == PWR_PER_PORT && port_power_mask[1] && !per_port_power_command[1])
      |=> port_power_on[1] == $past(port_power_on[1]))
    else $error("masked port followed global switch");

  // ==========================================================
  // Field writes
  a_fields_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_hit |=> $stable(fields_r))
    else $error("register changed without a full write");

  a_noprot_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> fields_r.no_overcurrent_protect == $past(apb_req.pwdata[`RHD_NOOC_BIT]))
    else $error("no-protection bit not written");

  a_ocmode_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> fields_r.overcurrent_report_mode == $past(apb_req.pwdata[`RHD_OCRM_BIT]))
    else $error("overcurrent mode bit not written");

  a_swmode_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> fields_r.power_switch_mode == $past(apb_req.pwdata[`RHD_PSWM_BIT]))
    else $error("power switch mode bit not written");

  a_swabsent_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> fields_r.power_switch_absent == $past(apb_req.pwdata[`RHD_PSA_BIT]))
    else $error("always-powered bit not written");

  // ==========================================================
  // Read data
  a_rd_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_reg) |->
      apb_rsp.prdata[`RHD_PGW_MSB:`RHD_PGW_LSB] == fields_r.power_good_wait_units)
    else $error("power-good wait read back wrong");

  a_rd_noprot: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_reg) |->
      apb_rsp.prdata[`RHD_NOOC_BIT] == fields_r.no_overcurrent_protect)
    else $error("no-protection bit read back wrong");

  a_rd_ocmode: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_reg) |->
      apb_rsp.prdata[`RHD_OCRM_BIT] == fields_r.overcurrent_report_mode)
    else $error("overcurrent mode bit read back wrong");

  a_rd_swmode: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_reg) |->
      apb_rsp.prdata[`RHD_PSWM_BIT] == fields_r.power_switch_mode)
    else $error("power switch mode bit read back wrong");

  a_rd_swabsent: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_reg) |->
      apb_rsp.prdata[`RHD_PSA_BIT] == fields_r.power_switch_absent)
    else $error("always-powered bit read back wrong");

  a_rd_count: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_reg) |->
      apb_rsp.prdata[`RHD_NPORT_MSB:`RHD_NPORT_LSB] == `RHD_NPORT_VALUE)
    else $error("port count read back wrong");

  a_rd_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !sel_reg) |->
      apb_rsp.prdata == 32'h00000000)
    else $error("unmapped read returned data");

  // ==========================================================
  // Bus answer
  a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable) |-> apb_rsp.pready)
    else $error("access phase not answered");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && !sel_reg) |-> apb_rsp.pslverr)
    else $error("unmapped access not flagged");

  a_partial_err: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && !full_word) |-> apb_rsp.pslverr)
    else $error("partial write not flagged");

  a_good_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && sel_reg && (!apb_req.pwrite || full_word))
      |-> !apb_rsp.pslverr)
    else $error("good access flagged as error");

  a_bad_wr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && !sel_reg) |=> $stable(fields_r))
    else $error("unmapped write changed register");

  // ==========================================================
  // Decoded modes
  a_oc_collective: assert property (@(posedge pclk) disable iff (!presetn)
    (!fields_r.no_overcurrent_protect && !fields_r.overcurrent_report_mode)
      |-> oc_mode == OC_COLLECTIVE)
    else $error("collective overcurrent mode not decoded");

  a_oc_per_port: assert property (@(posedge pclk) disable iff (!presetn)
    (!fields_r.no_overcurrent_protect && fields_r.overcurrent_report_mode)
      |-> oc_mode == OC_PER_PORT)
    else $error("per-port overcurrent mode not decoded");

  a_oc_protected: assert property (@(posedge pclk) disable iff (!presetn)
    !fields_r.no_overcurrent_protect |-> oc_mode != OC_NONE)
    else $error("protection reported absent while bit clear");

  a_pm_ganged: assert property (@(posedge pclk) disable iff (!presetn)
    (!fields_r.power_switch_absent && !fields_r.power_switch_mode)
      |-> power_mode == PWR_GANGED)
    else $error("ganged power mode not decoded");

  a_pm_per_port: assert property (@(posedge pclk) disable iff (!presetn)
    (!fields_r.power_switch_absent && fields_r.power_switch_mode)
      |-> power_mode == PWR_PER_PORT)
    else $error("per-port power mode not decoded");

  a_pm_always: assert property (@(posedge pclk) disable iff (!presetn)
    fields_r.power_switch_absent |-> power_mode == PWR_ALWAYS_ON)
    else $error("always-powered mode not decoded");

  a_pm_switched: assert property (@(posedge pclk) disable iff (!presetn)
    !fields_r.power_switch_absent |-> power_mode != PWR_ALWAYS_ON)
    else $error("switched ports reported always powered");

  // ==========================================================
  // Ganged port power
  a_ganged_global: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == PWR_GANGED && global_power_command)
      |=> port_power_on[15:1] == {15{$past(global_power_value)}})
    else $error("ganged ports missed the global switch");

  a_ganged_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == PWR_GANGED && !global_power_command) |=> $stable(port_power_on))
    else $error("ganged ports changed without a global command");

endmodule : root_hub_descriptor_config
`default_nettype wire

// ==== bench/root_hub_descriptor_config_tb.sv ====
// Self-checking bench for the root hub descriptor register block
`timescale 1ns/1ps
`default_nettype none
module root_hub_descriptor_config_tb;
  import root_hub_descriptor_config_pkg::*;
  // ==========================================
  // Signals and bench state
  localparam logic [31:0] ADDR = 32'h90101048;
  logic        pclk;
  logic        presetn;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [15:0] mask, ppc, ppv, pon, exp_pon;
  logic        gpc, gpv, er;
  power_mode_t pmode;
  oc_mode_t    ocm;
  logic [7:0]  pgw;
  logic [31:0] pgw_cyc, rd, d, mdl;
  int          n_mismatch = 0;
  int          checks = 0;
  int          seed = 32'h3d2ae360;
  // ==========================================
  // Design under test
  root_hub_descriptor_config root_hub_descriptor_config_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .port_power_mask(mask), .global_power_command(gpc), .global_power_value(gpv),
    .per_port_power_command(ppc), .per_port_power_value(ppv),
    .power_mode(pmode), .oc_mode(ocm), .power_good_wait_units(pgw),
    .power_good_wait_cycles(pgw_cyc), .port_power_on(pon));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ==========================================
  // Tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] s);
    req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= w;
    req.paddr <= a; req.pwdata <= wd; req.pstrb <= s;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task chk_cfg;
    logic [1:0] pm, om;
    pm = mdl[8] ? 2'b11 : (mdl[9] ? 2'b01 : 2'b00);
    om = mdl[12] ? 2'b11 : (mdl[11] ? 2'b01 : 2'b00);
    chk("power_mode", {30'h0, pm}, {30'h0, pmode});
    chk("oc_mode", {30'h0, om}, {30'h0, ocm});
    chk("pgw_units", {24'h0, mdl[31:24]}, {24'h0, pgw});
    chk("pgw_cycles", mdl[31:24] * 32'd500000, pgw_cyc);
  endtask : chk_cfg
  task pulse(input logic g, input logic gv, input logic [15:0] pc, input logic [15:0] pv);
    gpc <= g; gpv <= gv; ppc <= pc; ppv <= pv;
    @(posedge pclk);
    gpc <= 1'b0; ppc <= 16'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'b0; req = '0; mask = '0; ppc = '0; ppv = '0; gpc = 1'b0; gpv = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    mdl = 32'h01000a0f;
    apb(1'b0, ADDR, 32'h0, 4'hf);
    chk("reset_value", mdl, rd);
    chk_cfg();
    for (int i = 0; i < 32; i++) begin
      d = $random(seed);
      d[12:8] = i[4:0];
      apb(1'b1, ADDR, d, 4'hf);
      chk("write_err", 32'h0, {31'h0, er});
      mdl = (d & 32'hff001b00) | 32'h0000000f;
      apb(1'b0, ADDR, 32'h0, 4'hf);
      chk("readback", mdl, rd);
      chk_cfg();
    end
    apb(1'b0, 32'h9010104c, 32'h0, 4'hf);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, 32'h9010104c, $random(seed), 4'hf);
    chk("unmapped_wr_err", 32'h1, {31'h0, er});
    apb(1'b1, ADDR, ~mdl, 4'h3);
    chk("partial_err", 32'h1, {31'h0, er});
    apb(1'b0, ADDR, 32'h0, 4'hf);
    chk("no_change", mdl, rd);
    // Per-port power with a random mask, both command paths at once
    apb(1'b1, ADDR, 32'h00000200, 4'hf);
    d = $random(seed);
    mask <= d[15:0];
    d = $random(seed);
    pulse(1'b1, 1'b1, 16'hffff, d[15:0]);
    exp_pon = (~mask | (mask & ppv)) & 16'hfffe;
    chk("per_port_power", {16'h0, exp_pon}, {16'h0, pon});
    apb(1'b1, ADDR, 32'h00000000, 4'hf);
    pulse(1'b1, 1'b0, 16'h0, 16'h0);
    chk("ganged_off", 32'h0, {16'h0, pon});
    apb(1'b1, ADDR, 32'h00000100, 4'hf);
    @(posedge pclk);
    chk("always_on", 32'h0000fffe, {16'h0, pon});
    end_sim();
  end
endmodule : root_hub_descriptor_config_tb
`default_nettype wire
